// ### hdl/sllld_lock_qual.sv
// digital lock-detect qualifier, counting consecutive good comparison cycles
`timescale 1ns/1ns
`include "sllld_map.svh"
module sllld_lock_qual (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmp_cycle,
  input wire logic err_small,
  input wire logic err_large,
  input wire logic lock_precision,
  output logic lock_det
);
  import sllld_pkg::*;
  sllld_lock_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [2:0] need;
  always_comb begin
    need = lock_precision ? `SLLLD_LOCK_CNT_PRECISE : `SLLLD_LOCK_CNT_NORMAL;
    st_d = st_q;
    cnt_d = cnt_q;
    if (cmp_cycle) begin
      case (st_q)
        SLLLD_UNLOCKED: begin
          if (!err_small) begin
            cnt_d = 3'h0;
          end else if (cnt_q + 3'h1 >= need) begin
            st_d = SLLLD_LOCKED;
            cnt_d = 3'h0;
          end else begin
            cnt_d = cnt_q + 3'h1;
          end
        end
        SLLLD_LOCKED: begin
          if (err_large) begin
            st_d = SLLLD_UNLOCKED;
          end
        end
        default: begin
          st_d = SLLLD_UNLOCKED;
          cnt_d = 3'h0;
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= SLLLD_UNLOCKED;
      cnt_q <= 3'h0;
      lock_det <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lock_det <= (st_d == SLLLD_LOCKED);
    end
  end
endmodule

// ### hdl/sllld_map.svh
// register field positions, reset values and timing counts for the serial latch loader
`ifndef SLLLD_MAP_SVH
`define SLLLD_MAP_SVH
`define SLLLD_WORD_W 24
`define SLLLD_WORD_RST 24'h000000
`define SLLLD_SEL_REF 2'h0
`define SLLLD_SEL_FB 2'h1
`define SLLLD_SEL_FUNC 2'h2
`define SLLLD_SEL_INIT 2'h3
`define SLLLD_REF_DIV_MSB 15
`define SLLLD_REF_DIV_LSB 2
`define SLLLD_PW_SEL_HI 17
`define SLLLD_PW_SEL_LO 16
`define SLLLD_TEST_SEL_HI 19
`define SLLLD_TEST_SEL_LO 18
`define SLLLD_LOCK_PRECISION 20
`define SLLLD_GAIN_SELECT 21
`define SLLLD_FB_DIV_MSB 20
`define SLLLD_FB_DIV_LSB 8
`define SLLLD_SYNC_PD_SEL 21
`define SLLLD_CUR2_MSB 20
`define SLLLD_CUR2_LSB 18
`define SLLLD_CUR1_MSB 17
`define SLLLD_CUR1_LSB 15
`define SLLLD_TIMEOUT_MSB 14
`define SLLLD_TIMEOUT_LSB 11
`define SLLLD_FAST_KIND 10
`define SLLLD_FAST_ON 9
`define SLLLD_PUMP_TRI 8
`define SLLLD_CMP_POL 7
`define SLLLD_OUTSEL_MSB 6
`define SLLLD_OUTSEL_LSB 4
`define SLLLD_PD_REQ 3
`define SLLLD_DIV_CLEAR 2
`define SLLLD_LOCK_CNT_NORMAL 3'h3
`define SLLLD_LOCK_CNT_PRECISE 3'h5
`endif

// ### hdl/sllld_pkg.sv
// types for the serial latch loader
package sllld_pkg;
  typedef logic [23:0] sllld_word_t;
  typedef enum logic [2:0] {
    SLLLD_OUT_TRISTATE = 3'h0,
    SLLLD_OUT_DLOCK = 3'h1,
    SLLLD_OUT_FB_DIV = 3'h2,
    SLLLD_OUT_VDD = 3'h3,
    SLLLD_OUT_REF_DIV = 3'h4,
    SLLLD_OUT_ALOCK = 3'h5,
    SLLLD_OUT_SDO = 3'h6,
    SLLLD_OUT_GND = 3'h7
  } sllld_outsel_t;
  typedef enum logic [1:0] {
    SLLLD_UNLOCKED = 2'h0,
    SLLLD_LOCKED = 2'h1
  } sllld_lock_t;
endpackage

// ### hdl/sllld_top.sv
// serial programming port with four word latches, lock qualifier and status output select
// Notes on behaviour
// - each rising serial clock shifts data into a 24-bit register, msb first
// - rising latch strobe copies the shift register into exactly one latch
// - two lowest bits pick reference, feedback, function or initialization latch
// - reference divide value is 14 bits, feedback divide value 13 bits
// - reference word bits 17 and 16 choose the antibacklash pulse width
// - lock asserts after three consecutive small-error cycles when precision is clear
// - with precision bit set, five consecutive small-error cycles are needed
// - lock stays high until a comparison cycle shows a large error
// - function word bits 6 to 4 choose the status output source
// - analog lock source idles high with low pulses on open-drain output
// - comparator takes divided reference and feedback, reports their phase difference
// - feedback word holds gain bit 21, divide value 20 to 8
// - function word fields: powerdown, two currents, timeout, fast settle, polarity, clear
`timescale 1ns/1ns
`include "sllld_map.svh"
module sllld_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  input wire logic ref_div_pulse,
  input wire logic fb_div_pulse,
  input wire logic err_small,
  input wire logic err_large,
  output logic status_out_o,
  output logic status_out_oe,
  output logic [13:0] ref_div_value,
  output logic [12:0] fb_div_value,
  output logic [1:0] pulse_width_sel,
  output logic [1:0] test_sel,
  output logic gain_select,
  output logic sync_powerdown_sel,
  output logic [2:0] current_two,
  output logic [2:0] current_one,
  output logic [3:0] timeout_code,
  output logic fast_settle_kind,
  output logic fast_settle_on,
  output logic pump_tristate,
  output logic comparator_polarity,
  output logic powerdown_request,
  output logic divider_clear,
  output logic cmp_up,
  output logic cmp_down
);
  import sllld_pkg::*;
  // two-flop synchronisers; the first stage feeds only the second
  // a pin pulse shorter than one system cycle may slip between samples
  // data rides the same flops as the serial clock, so their order is kept
  logic [4:0] s1_q, s2_q, s3_q;
  logic [4:0] pins;
  assign pins = {fb_div_pulse, ref_div_pulse, latch_strobe, ser_data, ser_clk};
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  function automatic logic rise(input logic [4:0] now, input logic [4:0] old, input int i);
    rise = now[i] & ~old[i];
  endfunction
  logic clk_rise, le_rise, ref_rise, fb_rise;
  assign clk_rise = rise(s2_q, s3_q, 0);
  assign le_rise = rise(s2_q, s3_q, 2);
  assign ref_rise = rise(s2_q, s3_q, 3);
  assign fb_rise = rise(s2_q, s3_q, 4);

  // shift register and latches
  // latches reset to zero since no power-on values are defined for them
  sllld_word_t sh_q, sh_d;
  sllld_word_t lat_q [4];
  sllld_word_t lat_d [4];
  always_comb begin
    sh_d = sh_q;
    if (clk_rise) begin
      sh_d = {sh_q[22:0], s2_q[1]};
    end
  end
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lat
      always_comb begin
        lat_d[g] = lat_q[g];
        if (le_rise && sh_q[1:0] == 2'(g)) begin
          lat_d[g] = sh_q;
        end
      end
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          lat_q[g] <= `SLLLD_WORD_RST;
        end else begin
          lat_q[g] <= lat_d[g];
        end
      end
    end
  endgenerate
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sh_q <= `SLLLD_WORD_RST;
    end else begin
      sh_q <= sh_d;
    end
  end

  // the function fields come from whichever of function/init was loaded last
  // both words share one layout, so one field decoder serves both
  logic use_init_q, use_init_d;
  sllld_word_t fw;
  always_comb begin
    use_init_d = use_init_q;
    if (le_rise && sh_q[1:0] == `SLLLD_SEL_INIT) begin
      use_init_d = 1'b1;
    end else if (le_rise && sh_q[1:0] == `SLLLD_SEL_FUNC) begin
      use_init_d = 1'b0;
    end
    fw = use_init_q ? lat_q[`SLLLD_SEL_INIT] : lat_q[`SLLLD_SEL_FUNC];
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      use_init_q <= 1'b0;
    end else begin
      use_init_q <= use_init_d;
    end
  end

  // comparator: up on reference edge, down on feedback edge, both clear together
  // edges seen in the same cycle cancel at once, so zero phase error shows no state
  logic up_d, dn_d, cyc;
  always_comb begin
    up_d = cmp_up | ref_rise;
    dn_d = cmp_down | fb_rise;
    cyc = up_d & dn_d;
    if (cyc) begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end
  end
  logic lock_det;
  sllld_lock_qual u_lock (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cmp_cycle(cyc),
    .err_small(err_small),
    .err_large(err_large),
    .lock_precision(lat_q[`SLLLD_SEL_REF][`SLLLD_LOCK_PRECISION]),
    .lock_det(lock_det)
  );

  // status output: open-drain, so a high means release (oe low)
  // oe trails lock by one cycle, the price of driving the pin from a flop
  logic st_lvl, st_drive;
  sllld_outsel_t sel;
  always_comb begin
    sel = sllld_outsel_t'(fw[`SLLLD_OUTSEL_MSB:`SLLLD_OUTSEL_LSB]);
    st_drive = 1'b1;
    st_lvl = 1'b0;
    case (sel)
      SLLLD_OUT_TRISTATE: st_drive = 1'b0;
      SLLLD_OUT_DLOCK: st_lvl = lock_det;
      SLLLD_OUT_FB_DIV: st_lvl = s2_q[4];
      SLLLD_OUT_VDD: st_lvl = 1'b1;
      SLLLD_OUT_REF_DIV: st_lvl = s2_q[3];
      SLLLD_OUT_ALOCK: st_lvl = ~(cmp_up ^ cmp_down);
      SLLLD_OUT_SDO: st_lvl = sh_q[23];
      SLLLD_OUT_GND: st_lvl = 1'b0;
      default: st_lvl = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_out_o <= 1'b0;
      status_out_oe <= 1'b0;
      cmp_up <= 1'b0;
      cmp_down <= 1'b0;
      ref_div_value <= 14'h0000;
      fb_div_value <= 13'h0000;
      pulse_width_sel <= 2'h0;
      test_sel <= 2'h0;
      gain_select <= 1'b0;
      sync_powerdown_sel <= 1'b0;
      current_two <= 3'h0;
      current_one <= 3'h0;
      timeout_code <= 4'h0;
      fast_settle_kind <= 1'b0;
      fast_settle_on <= 1'b0;
      pump_tristate <= 1'b0;
      comparator_polarity <= 1'b0;
      powerdown_request <= 1'b0;
      divider_clear <= 1'b0;
    end else begin
      status_out_o <= 1'b0;
      status_out_oe <= st_drive & ~st_lvl;
      cmp_up <= up_d;
      cmp_down <= dn_d;
      ref_div_value <= lat_q[0][`SLLLD_REF_DIV_MSB:`SLLLD_REF_DIV_LSB];
      fb_div_value <= lat_q[1][`SLLLD_FB_DIV_MSB:`SLLLD_FB_DIV_LSB];
      pulse_width_sel <= lat_q[0][`SLLLD_PW_SEL_HI:`SLLLD_PW_SEL_LO];
      test_sel <= lat_q[0][`SLLLD_TEST_SEL_HI:`SLLLD_TEST_SEL_LO];
      gain_select <= lat_q[1][`SLLLD_GAIN_SELECT];
      sync_powerdown_sel <= fw[`SLLLD_SYNC_PD_SEL];
      current_two <= fw[`SLLLD_CUR2_MSB:`SLLLD_CUR2_LSB];
      current_one <= fw[`SLLLD_CUR1_MSB:`SLLLD_CUR1_LSB];
      timeout_code <= fw[`SLLLD_TIMEOUT_MSB:`SLLLD_TIMEOUT_LSB];
      fast_settle_kind <= fw[`SLLLD_FAST_KIND];
      fast_settle_on <= fw[`SLLLD_FAST_ON];
      pump_tristate <= fw[`SLLLD_PUMP_TRI];
      comparator_polarity <= fw[`SLLLD_CMP_POL];
      powerdown_request <= fw[`SLLLD_PD_REQ];
      divider_clear <= fw[`SLLLD_DIV_CLEAR];
    end
  end
endmodule

// ### verification/sllld_host.sv
// serial host model shifting words into the block
`timescale 1ns/1ns
module sllld_host (
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // 160 ns half period keeps each pin level for four system cycles
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data = w[i];
      #160 ser_clk = 1'b1;
      #160 ser_clk = 1'b0;
    end
    ser_data = ~w[0];
    #160 latch_strobe = 1'b1;
    #160 latch_strobe = 1'b0;
  endtask
endmodule

// ### verification/sllld_props.sv
// port assertions for the serial latch loader
`timescale 1ns/1ns
module sllld_props_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic latch_strobe,
  input wire logic ref_div_pulse,
  input wire logic fb_div_pulse,
  input wire logic status_out_o,
  input wire logic [13:0] ref_div_value,
  input wire logic [12:0] fb_div_value,
  input wire logic [1:0] pulse_width_sel,
  input wire logic gain_select,
  input wire logic [3:0] timeout_code,
  input wire logic cmp_up,
  input wire logic cmp_down
);
  logic stb_q;
  logic stb_d;
  logic [3:0] age_q;
  logic [3:0] age_d;
  // age saturates so a late change can never look like a fresh load
  always_comb begin
    stb_d = latch_strobe;
    age_d = (latch_strobe && !stb_q) ? 4'h0 : ((age_q == 4'hF) ? age_q : age_q + 4'h1);
    if (!rst_n) begin
      age_d = 4'hF;
    end
  end
  always_ff @(posedge sys_clk) begin
    stb_q <= stb_d;
    age_q <= age_d;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  drain_low_a: assert property (status_out_o == 1'b0) else $error("pin data not low");
  ref_hold_a: assert property ($changed(ref_div_value) |-> age_q < 4'hA) else $error("ref moved");
  fb_hold_a: assert property ($changed(fb_div_value) |-> age_q < 4'hA) else $error("fb moved");
  gain_hold_a: assert property ($changed(gain_select) |-> age_q < 4'hA) else $error("gain moved");
  timer_hold_a: assert property ($changed(timeout_code) |-> age_q < 4'hA) else $error("tc moved");
  pw_hold_a: assert property ($changed(pulse_width_sel) |-> age_q < 4'hA) else $error("pw moved");
  // an edge meeting a pending or near opposite edge closes the cycle with no state shown
  up_resp_a: assert property ($rose(ref_div_pulse) && !fb_div_pulse && !cmp_down
    && !$past(fb_div_pulse) && !$past(fb_div_pulse, 2) |-> ##[1:4] cmp_up)
    else $error("no up");
  down_resp_a: assert property ($rose(fb_div_pulse) && !ref_div_pulse && !cmp_up
    && !$past(ref_div_pulse) && !$past(ref_div_pulse, 2) |-> ##[1:4] cmp_down)
    else $error("no down");
endmodule
bind sllld_top sllld_props_chk chk (.sys_clk, .rst_n, .latch_strobe, .ref_div_pulse,
  .fb_div_pulse, .status_out_o, .ref_div_value, .fb_div_value, .pulse_width_sel,
  .gain_select, .timeout_code, .cmp_up, .cmp_down);

// ### verification/tb_serial_latch_loader_lock_detect.sv
// testbench for the serial latch loader with lock qualifier
`timescale 1ns/1ns
module tb_serial_latch_loader_lock_detect;
  logic sys_clk, rst_n, ref_div_pulse, fb_div_pulse, err_small, err_large;
  wire ser_clk, ser_data, latch_strobe, status_out_o, status_out_oe, gain_select;
  wire [13:0] ref_div_value;
  wire [12:0] fb_div_value;
  wire [1:0] pulse_width_sel, test_sel;
  wire [2:0] current_two, current_one;
  wire [3:0] timeout_code;
  wire sync_powerdown_sel, fast_settle_kind, fast_settle_on, pump_tristate;
  wire comparator_polarity, powerdown_request, divider_clear, cmp_up, cmp_down;
  int err_total = 0;
  int tests_run = 0;
  sllld_host host (.ser_clk, .ser_data, .latch_strobe);
  sllld_top dut (.sys_clk, .rst_n, .ser_clk, .ser_data, .latch_strobe, .ref_div_pulse,
    .fb_div_pulse, .err_small, .err_large, .status_out_o, .status_out_oe, .ref_div_value,
    .fb_div_value, .pulse_width_sel, .test_sel, .gain_select, .sync_powerdown_sel,
    .current_two, .current_one, .timeout_code, .fast_settle_kind, .fast_settle_on,
    .pump_tristate, .comparator_polarity, .powerdown_request, .divider_clear, .cmp_up,
    .cmp_down);
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic load(input logic [23:0] w);
    @(posedge sys_clk);
    #1;
    host.send(w);
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  // drive both divided pins and let four system cycles pass with them held
  task automatic pin(input logic r, input logic f);
    @(posedge sys_clk);
    #1;
    ref_div_pulse = r;
    fb_div_pulse = f;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [23:0] fw(input logic [1:0] c, input logic [2:0] m,
      input logic [3:0] t);
    return {3'h1, 6'h2A, t, 4'hA, m, 2'h2, c};
  endfunction
  // one comparison cycle: both divided edges together, error levels held meanwhile
  task automatic pd(input logic s, input logic l);
    @(posedge sys_clk);
    #1;
    err_small = s;
    err_large = l;
    ref_div_pulse = 1'b1;
    fb_div_pulse = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    ref_div_pulse = 1'b0;
    fb_div_pulse = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_ref();
    chk("ref reset", 24'h0, {10'h0, ref_div_value});
    // comparison rate here is far below the limit, so any pulse width is allowed
    load({4'h0, 2'h2, 2'h1, 14'h2A5B, 2'h0});
    chk("ref div", 24'h2A5B, {10'h0, ref_div_value});
    chk("pw sel", 24'h1, {22'h0, pulse_width_sel});
    chk("test sel", 24'h2, {22'h0, test_sel});
  endtask
  task automatic t_fb();
    load({2'h3, 1'h1, 13'h1ABC, 6'h2A, 2'h1});
    chk("fb div", 24'h1ABC, {11'h0, fb_div_value});
    chk("gain", 24'h1, {23'h0, gain_select});
    chk("ref kept", 24'h2A5B, {10'h0, ref_div_value});
  endtask
  task automatic t_func(input logic [1:0] c, input logic [3:0] t);
    logic [23:0] w;
    w = fw(c, 3'h1, t);
    load(w);
    chk("func hi", {9'h0, w[21:7]}, {9'h0, sync_powerdown_sel, current_two, current_one,
      timeout_code, fast_settle_kind, fast_settle_on, pump_tristate,
      comparator_polarity});
    chk("func lo", {22'h0, w[3:2]}, {22'h0, powerdown_request, divider_clear});
    chk("fb kept", 24'h1ABC, {11'h0, fb_div_value});
  endtask
  task automatic t_cmp();
    pin(1'b1, 1'b0);
    chk("up only", 24'h2, {22'h0, cmp_up, cmp_down});
    pin(1'b0, 1'b0);
    pin(1'b0, 1'b1);
    chk("up cycle", 24'h0, {22'h0, cmp_up, cmp_down});
    pin(1'b0, 1'b0);
    pin(1'b0, 1'b1);
    chk("down only", 24'h1, {22'h0, cmp_up, cmp_down});
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b0);
    chk("down cycle", 24'h0, {22'h0, cmp_up, cmp_down});
    pin(1'b0, 1'b0);
  endtask
  task automatic t_lock(input logic p, input int n);
    load({3'h0, p, 4'h9, 14'h2A5B, 2'h0});
    pd(1'b0, 1'b1);
    repeat (n - 1) pd(1'b1, 1'b0);
    chk("not yet", 24'h1, {23'h0, status_out_oe});
    pd(1'b1, 1'b0);
    chk("locked", 24'h0, {23'h0, status_out_oe});
    pd(1'b0, 1'b0);
    chk("held", 24'h0, {23'h0, status_out_oe});
    pd(1'b0, 1'b1);
    chk("dropped", 24'h1, {23'h0, status_out_oe});
  endtask
  task automatic t_mux();
    logic exp [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 8; i++) begin
      load(fw(2'h2, 3'(i), 4'h6));
      chk("mux oe", {23'h0, exp[i]}, {23'h0, status_out_oe});
      if (i == 2 || i == 4) begin
        pin(i == 4, i == 2);
        chk("mux pin", 24'h0, {23'h0, status_out_oe});
        pin(1'b0, 1'b0);
      end
    end
    chk("pin data", 24'h0, {23'h0, status_out_o});
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    rst_n = 1'b0;
    ref_div_pulse = 1'b0;
    fb_div_pulse = 1'b0;
    err_small = 1'b0;
    err_large = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_ref();
    t_fb();
    t_func(2'h2, 4'h6);
    t_func(2'h3, 4'h9);
    t_cmp();
    t_lock(1'b0, 3);
    t_lock(1'b1, 5);
    t_mux();
    stop_test();
  end
  // the whole run needs well under half a millisecond
  initial begin
    #2000000;
    err_total++;
    stop_test();
  end
endmodule
